/* File: rtl/rip_core.sv */
// Reset and interrupt priority resolver with priority and mode register.
// Assumes mode inputs are stable pins and request inputs come from logic
// clocked on clk_i; the CPU core consumes the winning request.
//
// Behaviour
// - After reset present the cause and mode restart vector within three cycles.
// - Reset sets both interrupt mask bits of the condition codes.
// - Reset sets the stop-disable bit of the condition codes.
// - Reset loads the priority select field with 0110, external interrupt.
// - External interrupt input is level sensitive until edge mode chosen.
// - Boot, special and mode-A bits capture mode pins at reset release.
// - Special bit is inverted mode-B input; mode-A bit is mode-A input.
// - In special modes, writing the mode bits changes the operating mode.
// - Reset sets the oscillator startup delay bit.
// - Reset clears the clock monitor enable bit.
// - Watchdog active only when disable bit clear; rate starts shortest.
// - Nonmaskable order: reset, clock monitor, watchdog, pin, illegal, trap.
// - Default maskable order runs external interrupt first, serial last.
// - Selected source goes top; others keep their default order.
// - Promoted source is still gated by global mask; local masks gate all but external interrupt.
// - Promotion never changes any vector address.
// - Priority select writes accepted only while maskable mask bit set.
// - Boot bit writable only in special mode, otherwise reads zero.
// - Visibility bit: read visibility if expanded, else E clock pin enable.
// - Register reset: field 0110, mode bits from pins, visibility in test.
// - Select codes map sources; reserved 0101 behaves like 0110.
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
module rip_core (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic mode_a_input_i,
	input wire logic mode_b_input_i,
	input wire logic [1:0] reset_cause_i,
	input wire logic watchdog_disable_i,
	input wire logic nonmaskable_irq_pin_i,
	input wire logic irq_pin_i,
	input wire logic illegal_op_i,
	input wire logic software_trap_i,
	input wire logic [NUM_MASK-1:0] mask_req_i,
	input wire logic [NUM_MASK-1:0] local_en_i,
	input wire logic irq_ack_i,
	input wire logic ccr_wr_i,
	input wire logic [7:0] ccr_wdata_i,
	input wire logic [15:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	output logic [7:0] ccr_o,
	output logic fetch_vec_o,
	output logic run_o,
	output logic req_valid_o,
	output logic [15:0] req_vec_o,
	output logic irq_edge_mode_o,
	output logic startup_delay_bit_o,
	output logic clock_monitor_enable_o,
	output logic watchdog_active_o,
	output logic [1:0] watchdog_rate_o,
	output logic read_vis_en_o,
	output logic eclk_pin_en_o
);
	import rip_pkg::*;

	logic ma_s1_r, ma_s2_r, mb_s1_r, mb_s2_r;
	logic irq_s1_r, irq_s2_r, irq_d_r, irq_edge_r;
	logic nm_s1_r, nm_s2_r;
	logic boot_r, special_mode_bit_r, mda_r, rvis_r, caught_r;
	logic [3:0] psel_r;
	logic [7:0] option_r, ccr_r, rdata_r;
	logic [1:0] cause_r;
	rip_state_t state_r, state_nxt;
	logic [1:0] cnt_r;
	logic wdog_act_r;
	logic [15:0] vec_nxt;
	logic val_nxt;

	// Mode pins run free through reset, so their levels are settled at
	// release; a reset here would hide the pins for two more edges.
	always_ff @(posedge clk_i) begin
		ma_s1_r <= mode_a_input_i;
		ma_s2_r <= ma_s1_r;
		mb_s1_r <= mode_b_input_i;
		mb_s2_r <= mb_s1_r;
	end

	// Request pins are active low; reset to idle so no false request
	// or false edge follows reset.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			irq_s1_r <= 1'b1;
			irq_s2_r <= 1'b1;
			nm_s1_r <= 1'b1;
			nm_s2_r <= 1'b1;
		end else begin
			irq_s1_r <= irq_pin_i;
			irq_s2_r <= irq_s1_r;
			nm_s1_r <= nonmaskable_irq_pin_i;
			nm_s2_r <= nm_s1_r;
		end
	end

	function automatic logic is_wr(input logic [15:0] a);
		return wr_i && addr_i == a;
	endfunction

	// Priority and mode register; mode bits caught in the first cycle
	// after release, once the pin samples are through the synchroniser.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			caught_r <= 1'b0;
			boot_r <= 1'b0;
			special_mode_bit_r <= 1'b0;
			mda_r <= 1'b0;
			rvis_r <= 1'b0;
			psel_r <= PSEL_RESET;
			cause_r <= 2'b00;
		end else if (!caught_r) begin
			caught_r <= 1'b1;
			cause_r <= reset_cause_i;
			special_mode_bit_r <= ~mb_s2_r;
			mda_r <= ma_s2_r;
			boot_r <= ~mb_s2_r & ~ma_s2_r;
			rvis_r <= ~mb_s2_r & ma_s2_r;
		end else if (is_wr(PRIO_REG_ADDR)) begin
			// Special modes may leave to any mode; normal modes are locked
			if (special_mode_bit_r) begin
				special_mode_bit_r <= wdata_i[SPECIAL_MODE_BIT_BIT];
				mda_r <= wdata_i[MDA_BIT];
				boot_r <= wdata_i[BOOT_BIT];
			end else begin
				boot_r <= 1'b0;
			end
			rvis_r <= wdata_i[RVIS_BIT];
			if (ccr_r[CCR_I])
				psel_r <= wdata_i[3:0];
		end else if (!special_mode_bit_r) begin
			boot_r <= 1'b0;
		end
	end

	// Option bits: edge select, startup delay, clock monitor, watchdog rate
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			option_r <= OPTION_RESET;
		else if (is_wr(OPTION_ADDR))
			option_r <= wdata_i & OPTION_MASK;
	end

	// Condition code mask bits held here on behalf of the core
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			ccr_r <= CCR_RESET;
		else if (ccr_wr_i)
			ccr_r <= ccr_wdata_i & CCR_MASK;
	end

	// Watchdog enable sampled once out of reset from the disable bit
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			wdog_act_r <= 1'b0;
		else if (!caught_r)
			wdog_act_r <= ~watchdog_disable_i;
	end

	// Edge detector on the synchronised line; latched until acknowledged
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			irq_d_r <= 1'b1;
			irq_edge_r <= 1'b0;
		end else begin
			irq_d_r <= irq_s2_r;
			// Falling edge of the active-low pin; set wins over acknowledge
			if (!irq_s2_r && irq_d_r)
				irq_edge_r <= 1'b1;
			else if (irq_ack_i && req_vec_o[7:0] == DEF_VEC[0])
				irq_edge_r <= 1'b0;
		end
	end

	// Restart sequence: vector stands during the three wait cycles after the fetch cycle
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			RIP_VEC_FETCH: state_nxt = RIP_VEC_WAIT;
			RIP_VEC_WAIT: if (cnt_r == 2'(VEC_CYCLES))
				state_nxt = RIP_RUN;
			RIP_RUN: state_nxt = RIP_RUN;
			default: state_nxt = RIP_VEC_FETCH;
		endcase
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_r <= RIP_VEC_FETCH;
			cnt_r <= 2'd0;
		end else begin
			state_r <= state_nxt;
			if (state_r != RIP_RUN)
				cnt_r <= cnt_r + 2'd1;
		end
	end

	function automatic logic [15:0] vec_of(input logic [7:0] lo);
		// Vectors move to the boot area in special modes only on restart
		return {VEC_NORM_BASE[15:8], lo};
	endfunction

	// Arbitration over nonmaskable then maskable sources
	always_comb begin
		logic [NUM_MASK-1:0] pend;
		logic [3:0] top;
		logic hit;
		pend = '0;
		top = (psel_r == PSEL_RESVD) ? PSEL_RESET : psel_r;
		hit = 1'b0;
		val_nxt = 1'b0;
		vec_nxt = '0;
		for (int k = 0; k < NUM_MASK; k++)
			pend[k] = mask_req_i[k] & local_en_i[k];
		// Level mode holds request while pin low; edge mode uses latch
		pend[0] = option_r[EDGE_BIT] ? irq_edge_r : ~irq_s2_r;
		if (state_r != RIP_RUN) begin
			// Cause and mode are valid only once caught after release
			val_nxt = caught_r;
			vec_nxt = {(special_mode_bit_r ? VEC_SPEC_BASE[15:8] : VEC_NORM_BASE[15:8]),
				(cause_r == 2'd1) ? VEC_CMF :
				(cause_r == 2'd2) ? VEC_WDOG : VEC_POR};
		end else if (!nm_s2_r && !ccr_r[CCR_X]) begin
			val_nxt = 1'b1;
			vec_nxt = vec_of(VEC_NONMASKABLE_IRQ_PIN);
		end else if (illegal_op_i) begin
			val_nxt = 1'b1;
			vec_nxt = vec_of(VEC_ILL);
		end else if (software_trap_i) begin
			val_nxt = 1'b1;
			vec_nxt = vec_of(VEC_SWI);
		end else if (!ccr_r[CCR_I]) begin
			for (int k = 0; k < NUM_MASK; k++)
				if (DEF_CODE[k] == top && pend[k]) begin
					hit = 1'b1;
					vec_nxt = vec_of(DEF_VEC[k]);
				end
			for (int k = NUM_MASK - 1; k >= 0; k--)
				if (!hit && pend[k]) begin
					val_nxt = 1'b1;
					vec_nxt = vec_of(DEF_VEC[k]);
				end
			if (hit)
				val_nxt = 1'b1;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			req_valid_o <= 1'b0;
			req_vec_o <= '0;
			fetch_vec_o <= 1'b1;
			run_o <= 1'b0;
		end else begin
			req_valid_o <= val_nxt;
			req_vec_o <= vec_nxt;
			// Phase flags registered beside the winner so they line up
			fetch_vec_o <= (state_r != RIP_RUN);
			run_o <= (state_r == RIP_RUN);
		end
	end


	// Read port: data in the cycle after the strobe
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			rdata_r <= '0;
		else if (rd_i) begin
			if (addr_i == PRIO_REG_ADDR)
				rdata_r <= {boot_r & special_mode_bit_r, special_mode_bit_r, mda_r, rvis_r, psel_r};
			else if (addr_i == OPTION_ADDR)
				rdata_r <= option_r;
			else if (addr_i == CCR_ADDR)
				rdata_r <= ccr_r;
			else
				rdata_r <= '0;
		end
	end

	assign rdata_o = rdata_r;
	assign ccr_o = ccr_r;
	assign irq_edge_mode_o = option_r[EDGE_BIT];
	assign startup_delay_bit_o = option_r[DLY_BIT];
	assign clock_monitor_enable_o = option_r[CME_BIT];
	assign watchdog_active_o = wdog_act_r;
	assign watchdog_rate_o = option_r[1:0];
	// Expanded modes use visibility; single-chip and bootstrap gate E pin
	assign read_vis_en_o = mda_r & rvis_r;
	assign eclk_pin_en_o = ~mda_r & rvis_r;
endmodule // rip_core

/* File: rtl/rip_pkg.sv */
// Constants for the reset and interrupt priority resolver.
// Assumes a single 25 MHz clock and a byte-wide register port.
package rip_pkg;
	localparam int CLK_MHZ = 25;
	localparam logic [15:0] PRIO_REG_ADDR = 16'h103C;
	localparam logic [15:0] OPTION_ADDR = 16'h1039;
	localparam logic [15:0] CCR_ADDR = 16'h10F0;
	// Priority register fields
	localparam int BOOT_BIT = 7;
	localparam int SPECIAL_MODE_BIT_BIT = 6;
	localparam int MDA_BIT = 5;
	localparam int RVIS_BIT = 4;
	localparam logic [3:0] PSEL_RESET = 4'h6;
	localparam logic [3:0] PSEL_RESVD = 4'h5;
	// Option register fields
	localparam int EDGE_BIT = 5;
	localparam int DLY_BIT = 4;
	localparam int CME_BIT = 3;
	localparam logic [7:0] OPTION_RESET = 8'h10;
	localparam logic [7:0] OPTION_MASK = 8'h3B;
	// Condition code mask bits: stop-disable, nonmaskable, maskable
	localparam int CCR_S = 7;
	localparam int CCR_X = 6;
	localparam int CCR_I = 4;
	localparam logic [7:0] CCR_RESET = 8'hD0;
	localparam logic [7:0] CCR_MASK = 8'hD0;
	localparam int VEC_CYCLES = 3;
	localparam int NUM_MASK = 15;
	// Vectors
	localparam logic [15:0] VEC_NORM_BASE = 16'hFF00;
	localparam logic [15:0] VEC_SPEC_BASE = 16'hBF00;
	localparam logic [7:0] VEC_POR = 8'hFE;
	localparam logic [7:0] VEC_CMF = 8'hFC;
	localparam logic [7:0] VEC_WDOG = 8'hFA;
	localparam logic [7:0] VEC_NONMASKABLE_IRQ_PIN = 8'hF4;
	localparam logic [7:0] VEC_ILL = 8'hF8;
	localparam logic [7:0] VEC_SWI = 8'hF6;
	// Default maskable order, index = rank
	localparam logic [3:0] DEF_CODE [NUM_MASK] = '{4'h6, 4'h7, 4'h8, 4'h9,
		4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF, 4'h0, 4'h1, 4'h2, 4'h3, 4'h4};
	localparam logic [7:0] DEF_VEC [NUM_MASK] = '{8'hF2, 8'hF0, 8'hEE,
		8'hEC, 8'hEA, 8'hE8, 8'hE6, 8'hE4, 8'hE2, 8'hE0, 8'hDE, 8'hDC,
		8'hDA, 8'hD8, 8'hD6};
	typedef enum logic [2:0] {
		RIP_VEC_FETCH = 3'b001,
		RIP_VEC_WAIT = 3'b010,
		RIP_RUN = 3'b100
	} rip_state_t;
endpackage

/* File: test/rip_core_props.sv */
// Port checker for the reset and interrupt priority resolver.
// Assumes it is bound onto rip_core and sees its single clock domain.
`timescale 1ns/1ps
module rip_core_props (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic rd_i,
	input wire logic [15:0] addr_i,
	input wire logic illegal_op_i,
	input wire logic software_trap_i,
	input wire logic watchdog_disable_i,
	input wire logic [7:0] rdata_o,
	input wire logic [7:0] ccr_o,
	input wire logic fetch_vec_o,
	input wire logic run_o,
	input wire logic req_valid_o,
	input wire logic [15:0] req_vec_o,
	input wire logic startup_delay_bit_o,
	input wire logic clock_monitor_enable_o,
	input wire logic watchdog_active_o,
	input wire logic [1:0] watchdog_rate_o
);
	import rip_pkg::*;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic rd_q_r;
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) rd_q_r <= 1'b0;
		else rd_q_r <= rd_i && addr_i == PRIO_REG_ADDR;
	end
	sequence released_s;
		$fell(rst_i);
	endsequence
	sequence restart_s;
		fetch_vec_o && req_valid_o;
	endsequence
	ccr_masks_a: assert property (released_s |-> ccr_o[CCR_X] && ccr_o[CCR_I])
		else $error("mask bits clear after reset");
	stop_block_a: assert property (released_s |-> ccr_o[CCR_S])
		else $error("stop disable clear after reset");
	delay_set_a: assert property (released_s |-> startup_delay_bit_o)
		else $error("startup delay clear after reset");
	clock_mon_off_a: assert property (released_s |-> !clock_monitor_enable_o)
		else $error("clock monitor on after reset");
	watchdog_init_a: assert property (released_s |=> ##1
		watchdog_active_o == !watchdog_disable_i && watchdog_rate_o == 2'h0)
		else $error("watchdog start state wrong");
	restart_fetch_a: assert property (released_s |-> ##[0:3] restart_s)
		else $error("restart vector late");
	trap_order_a: assert property (run_o && req_valid_o &&
		req_vec_o == {8'hFF, VEC_SWI} |-> !$past(illegal_op_i))
		else $error("trap served over illegal opcode");
	mask_gate_a: assert property (run_o && req_valid_o &&
		req_vec_o[7:0] <= 8'hF2 |-> !$past(ccr_o[CCR_I]))
		else $error("maskable served while masked");
	boot_zero_a: assert property (rd_q_r && !rdata_o[SPECIAL_MODE_BIT_BIT] |->
		!rdata_o[BOOT_BIT]) else $error("boot bit set outside special");
	vec_fixed_a: assert property (run_o && req_valid_o |->
		req_vec_o[15:8] == 8'hFF && !req_vec_o[0]) else $error("bad vector");
endmodule // rip_core_props
bind rip_core rip_core_props u_props (.clk_i, .rst_i, .rd_i, .addr_i,
	.illegal_op_i, .software_trap_i, .watchdog_disable_i, .rdata_o, .ccr_o,
	.fetch_vec_o, .run_o, .req_valid_o, .req_vec_o, .startup_delay_bit_o,
	.clock_monitor_enable_o, .watchdog_active_o, .watchdog_rate_o);

/* File: test/rip_cpu_model.sv */
// CPU core stand-in: acknowledges maskable vectors, writes condition bits.
// Assumes the resolver's registered winner outputs.
`timescale 1ns/1ps
module rip_cpu_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic slow_i,
	input wire logic req_valid_i,
	input wire logic [15:0] req_vec_i,
	output logic irq_ack_o,
	output logic ccr_wr_o,
	output logic [7:0] ccr_wdata_o
);
	logic [1:0] wait_r;
	initial begin
		ccr_wr_o = 1'b0;
		ccr_wdata_o = 8'h00;
	end
	// Takes only the single presented winner, promptly or after a stall
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wait_r <= 2'h0;
			irq_ack_o <= 1'b0;
		end else begin
			irq_ack_o <= 1'b0;
			wait_r <= 2'h0;
			if (req_valid_i && req_vec_i[7:0] <= 8'hF2 && !irq_ack_o) begin
				wait_r <= wait_r + 2'h1;
				irq_ack_o <= wait_r >= (slow_i ? 2'h3 : 2'h1);
			end
		end
	end
	// Data is scrambled once released so a stale value never passes
	task automatic set_ccr(input logic [7:0] v);
		@(posedge clk_i);
		ccr_wr_o <= 1'b1;
		ccr_wdata_o <= v;
		@(posedge clk_i);
		ccr_wr_o <= 1'b0;
		ccr_wdata_o <= ~v;
	endtask
endmodule // rip_cpu_model

/* File: test/reset_interrupt_priority_tb.sv */
// Self-checking bench for rip_core with a CPU stand-in.
// Assumes a 25 MHz clock and registered winner outputs.
`timescale 1ns/1ps
module reset_interrupt_priority_tb;
	import rip_pkg::*;
	logic clk_i, rst_i, mode_a_input_i, mode_b_input_i, watchdog_disable_i;
	logic nonmaskable_irq_pin_i, irq_pin_i, illegal_op_i, software_trap_i;
	logic wr_i, rd_i, irq_ack_i, ccr_wr_i, slow, fetch_vec_o, run_o;
	logic req_valid_o, irq_edge_mode_o, startup_delay_bit_o, read_vis_en_o;
	logic clock_monitor_enable_o, watchdog_active_o, eclk_pin_en_o;
	logic [1:0] reset_cause_i, watchdog_rate_o;
	logic [NUM_MASK-1:0] mask_req_i, local_en_i;
	logic [15:0] addr_i, req_vec_o;
	logic [7:0] wdata_i, rdata_o, ccr_o, ccr_wdata_i, rv;
	logic [3:0] ps;
	logic [31:0] seed;
	int miscompares, checks_done;
	rip_core dut (.clk_i, .rst_i, .mode_a_input_i, .mode_b_input_i,
		.reset_cause_i, .watchdog_disable_i, .nonmaskable_irq_pin_i,
		.irq_pin_i, .illegal_op_i, .software_trap_i, .mask_req_i,
		.local_en_i, .irq_ack_i, .ccr_wr_i, .ccr_wdata_i, .addr_i, .wdata_i,
		.wr_i, .rd_i, .rdata_o, .ccr_o, .fetch_vec_o, .run_o, .req_valid_o,
		.req_vec_o, .irq_edge_mode_o, .startup_delay_bit_o,
		.clock_monitor_enable_o, .watchdog_active_o, .watchdog_rate_o,
		.read_vis_en_o, .eclk_pin_en_o);
	rip_cpu_model cpu (.clk_i, .rst_i, .slow_i(slow), .req_valid_i(req_valid_o),
		.req_vec_i(req_vec_o), .irq_ack_o(irq_ack_i), .ccr_wr_o(ccr_wr_i),
		.ccr_wdata_o(ccr_wdata_i));
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Reserved select matches no code, so it falls back to rank 0
	function automatic logic [16:0] win(input logic [3:0] p_sel,
		input logic [14:0] rq, en, input logic irq_n);
		logic [14:0] p;
		int top;
		p = rq & en;
		p[0] = !irq_n;
		top = 0;
		for (int k = 0; k < NUM_MASK; k++) if (DEF_CODE[k] == p_sel) top = k;
		if (p[top]) return {1'b1, 8'hFF, DEF_VEC[top]};
		for (int k = 0; k < NUM_MASK; k++) if (p[k]) return {1'b1, 8'hFF, DEF_VEC[k]};
		return 17'h0;
	endfunction
	task automatic chk(input logic [16:0] got, exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a);
		@(posedge clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 rv = rdata_o;
	endtask
	function automatic logic [16:0] winner();
		return {req_valid_o, req_valid_o ? req_vec_o : 16'h0};
	endfunction
	task automatic rst_to(input logic [1:0] m);
		int k;
		logic [1:0] c;
		c = 2'(xs() % 3);
		@(posedge clk_i);
		rst_i <= 1'b1;
		{mode_b_input_i, mode_a_input_i} <= m;
		reset_cause_i <= c;
		watchdog_disable_i <= 1'(xs());
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		for (k = 0; k < 8; k++) begin
			@(posedge clk_i);
			#1;
			if (fetch_vec_o && req_valid_o) break;
		end
		if (k == 8) begin
			miscompares++;
			give_verdict();
		end
		chk(winner(), {1'b1, m[1] ? 8'hFF : 8'hBF, c == 2'h0 ? VEC_POR :
			c == 2'h1 ? VEC_CMF : VEC_WDOG});
	endtask
	task automatic nm(input logic [2:0] s, input logic [7:0] v);
		@(posedge clk_i);
		{nonmaskable_irq_pin_i, illegal_op_i, software_trap_i} <= s;
		repeat (4) @(posedge clk_i);
		#1 chk(winner(), {1'b1, 8'hFF, v});
	endtask
	initial begin
		repeat (50000) @(posedge clk_i);
		miscompares++;
		give_verdict();
	end
	initial begin
		seed = 32'hA40D;
		{rst_i, nonmaskable_irq_pin_i, irq_pin_i, slow} = 4'hE;
		{mode_a_input_i, mode_b_input_i, watchdog_disable_i, wr_i, rd_i} = 5'h0;
		{illegal_op_i, software_trap_i, reset_cause_i, addr_i, wdata_i} = 28'h0;
		{mask_req_i, local_en_i} = 30'h0;
		miscompares = 0;
		checks_done = 0;
		for (int m = 0; m < 4; m++) begin
			rst_to(2'(m));
			rd(PRIO_REG_ADDR);
			chk(rv, {!m[0] && !m[1], !m[1], m[0], m[0] && !m[1], PSEL_RESET});
			chk(ccr_o, CCR_RESET);
			chk({irq_edge_mode_o, startup_delay_bit_o, clock_monitor_enable_o,
				watchdog_rate_o}, 5'h08);
			chk(watchdog_active_o, !watchdog_disable_i);
			wr(PRIO_REG_ADDR, rv ^ 8'hA0);
			rd(PRIO_REG_ADDR);
			chk(rv[7:5], m[1] ? {2'h0, m[0]} : {m[0], 1'b1, !m[0]});
		end
		repeat (60) begin
			ps = 4'(xs());
			cpu.set_ccr(CCR_RESET);
			wr(PRIO_REG_ADDR, {4'h0, ps});
			cpu.set_ccr(8'h00);
			wr(PRIO_REG_ADDR, {4'h0, ~ps});
			rd(PRIO_REG_ADDR);
			chk(rv[3:0], ps);
			@(posedge clk_i);
			slow <= 1'(xs());
			mask_req_i <= 15'(xs());
			local_en_i <= 15'(xs());
			irq_pin_i <= 1'(xs());
			repeat (4) @(posedge clk_i);
			#1 chk(winner(), win(ps, mask_req_i, local_en_i, irq_pin_i));
			cpu.set_ccr(CCR_RESET);
			repeat (3) @(posedge clk_i);
			#1 chk(req_valid_o, 1'b0);
			@(posedge clk_i);
			mask_req_i <= 15'h0;
			irq_pin_i <= 1'b1;
		end
		cpu.set_ccr(8'h00);
		wr(OPTION_ADDR, 8'h20);
		#1 chk(irq_edge_mode_o, 1'b1);
		@(posedge clk_i);
		irq_pin_i <= 1'b0;
		@(posedge clk_i);
		irq_pin_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		#1 chk(winner(), {1'b1, 8'hFF, DEF_VEC[0]});
		nm(3'b011, VEC_NONMASKABLE_IRQ_PIN);
		nm(3'b111, VEC_ILL);
		nm(3'b101, VEC_SWI);
		give_verdict();
	end
endmodule // reset_interrupt_priority_tb
